// ==== icc_pkg.sv ====
// Constants shared by the interface and clock configuration register bank.
package icc_pkg;

  // Register addresses as carried in the serial instruction byte.
  localparam logic [5:0] OFS_TX_FORMAT = 6'h13;
  localparam logic [5:0] OFS_IO_CFG = 6'h14;
  localparam logic [5:0] OFS_CLK_PRI = 6'h15;
  localparam logic [5:0] OFS_CLK_SEC = 6'h16;

  // Reset values; the duplex select bit resets high.
  localparam logic [7:0] RST_TX_FORMAT = 8'h00;
  localparam logic [7:0] RST_IO_CFG = 8'h10;
  localparam logic [7:0] RST_CLK_PRI = 8'h00;
  localparam logic [7:0] RST_CLK_SEC = 8'h00;

  // Implemented bits of each register; the rest read as zero.
  localparam logic [7:0] MASK_TX_FORMAT = 8'h03;
  localparam logic [7:0] MASK_IO_CFG = 8'h3F;
  localparam logic [7:0] MASK_CLK_PRI = 8'hBF;
  localparam logic [7:0] MASK_CLK_SEC = 8'h24;

  // Field positions in the transmit format register.
  localparam int INTERP_LSB = 0;
  localparam int INTERP_W = 2;

  // Field positions in the interface configuration register.
  localparam int IO_LOOPBACK = 5;
  localparam int IO_DUPLEX = 4;
  localparam int IO_DIRECTION = 3;
  localparam int IO_WIDTH = 2;
  localparam int IO_DIR_OVERRIDE = 1;
  localparam int IO_CLONE = 0;

  // Field positions in the primary clock register.
  localparam int CLK_BYPASS = 7;
  localparam int CLK_RX_HALF = 5;
  localparam int CLK_ALT_TIMING = 4;
  localparam int CLK_DIV5 = 3;
  localparam int MULT_LSB = 0;
  localparam int MULT_W = 3;

  // Field positions in the secondary clock register.
  localparam int CLK_AUX_OUT = 5;
  localparam int CLK_LOOP_BW = 2;

  // Interpolation codes.
  localparam logic [1:0] INTERP_NONE = 2'h0;
  localparam logic [1:0] INTERP_2X = 2'h1;
  localparam logic [1:0] INTERP_4X = 2'h2;

  // Highest multiplier code that names a real factor (16x).
  localparam logic [2:0] MULT_CODE_MAX = 3'h4;
  localparam logic [2:0] MULT_CODE_1X = 3'h0;

  // Instruction byte layout.
  localparam int INSTR_READ = 7;
  localparam int INSTR_TWO_BYTE = 6;

  // Rising serial clock edge counts that close each phase.
  localparam logic [4:0] EDGES_INSTR = 5'h08;
  localparam logic [4:0] EDGES_BYTE1 = 5'h10;
  localparam logic [4:0] EDGES_BYTE2 = 5'h18;

  // Serial port sequencer states, one-hot.
  typedef enum logic [4:0] {
    SP_IDLE = 5'h01,
    SP_INSTR = 5'h02,
    SP_WRITE = 5'h04,
    SP_READ = 5'h08,
    SP_DONE = 5'h10
  } icc_sp_state_type;

endpackage

// ==== icc_sync.sv ====
// Two-stage synchroniser for inputs arriving from outside the clock domain.
`timescale 1ns/100ps
module icc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Asynchronous input and its synchronised copy.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage; only the second stage reads it, to contain metastability.
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  // Second stage, safe for logic to read.
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // Next values simply walk the input down the chain.
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Both stages clear under the synchronous reset.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// ==== icc_config_top.sv ====
// Serial-programmed interface and clock configuration register bank.
`timescale 1ns/100ps
module icc_config_top (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Serial port pins.
  input wire logic sen_b,
  input wire logic sclk,
  input wire logic sdio_in,
  output logic sdo_out,
  output logic sdo_oe,
  // External transmit/receive select pin, high for transmit.
  input wire logic tx_rx_select,
  // Clock configuration bit held elsewhere in the device, same clock.
  input wire logic aux_clock_config_enable,
  // Transmit path controls.
  output logic tx_interp_bypass,
  output logic tx_interp_2x,
  output logic tx_interp_4x,
  output logic digital_loopback_enable,
  // Data interface mode.
  output logic full_duplex_mode,
  output logic half_duplex_narrow_mode,
  output logic half_duplex_wide_mode,
  output logic clone_mode_enable,
  output logic half_duplex_direction,
  // Clock distribution selects.
  output logic mult_bypass,
  output logic [2:0] mult_factor_sel,
  output logic multiplier_output_fifth_divide,
  output logic rx_clock_half,
  output logic rx_clock_from_multiplier,
  output logic multiplied_clock_to_aux_output,
  output logic mult_loop_alt_bandwidth
);

  // Synchronised pin levels: enable, serial clock, data in, direction pin.
  logic [3:0] pins_sync;
  logic sen_s;
  logic sclk_s;
  logic sdi_s;
  logic dir_pin_s;

  // Previous synchronised serial clock, for edge detection.
  logic sclk_prev_q;
  logic sclk_prev_d;
  logic sclk_rise;
  logic sclk_fall;

  // Serial sequencer state.
  icc_pkg::icc_sp_state_type sp_q;
  icc_pkg::icc_sp_state_type sp_d;
  // Rising edges counted in the current frame.
  logic [4:0] edge_cnt_q;
  logic [4:0] edge_cnt_d;
  // Incoming bits, most significant first.
  logic [7:0] shift_in_q;
  logic [7:0] shift_in_d;
  // Decoded instruction fields.
  logic two_byte_q;
  logic two_byte_d;
  logic [5:0] addr_q;
  logic [5:0] addr_d;
  // First data byte of a two-byte write, held until the frame completes.
  logic [7:0] hold_q;
  logic [7:0] hold_d;
  // Readback data for up to two bytes.
  logic [15:0] shift_out_q;
  logic [15:0] shift_out_d;
  // Serial output pin and its enable.
  logic sdo_q;
  logic sdo_d;
  logic sdo_oe_q;
  logic sdo_oe_d;

  // Write ports used at commit: two bytes may land in one cycle.
  logic wr0_en;
  logic [5:0] wr0_addr;
  logic [7:0] wr0_data;
  logic wr1_en;
  logic [5:0] wr1_addr;
  logic [7:0] wr1_data;
  // Next incoming byte after the current sample is shifted in.
  logic [7:0] byte_in;
  logic [4:0] edge_next;

  // Register storage, indexed by slot.
  logic [7:0] regs_q [0:3];
  logic [7:0] regs_d [0:3];

  // Registered outputs and their next values.
  logic [14:0] outs_q;
  logic [14:0] outs_d;
  logic [2:0] factor_q;
  logic [2:0] factor_d;

  // Maps an address to {hit, slot}; misses read zero and drop writes.
  function automatic logic [2:0] reg_slot(input logic [5:0] addr);
    logic [2:0] r;
    r = 3'h0;
    case (addr)
      icc_pkg::OFS_TX_FORMAT: begin
        r = 3'h4;
      end
      icc_pkg::OFS_IO_CFG: begin
        r = 3'h5;
      end
      icc_pkg::OFS_CLK_PRI: begin
        r = 3'h6;
      end
      icc_pkg::OFS_CLK_SEC: begin
        r = 3'h7;
      end
      default: begin
        r = 3'h0;
      end
    endcase
    return r;
  endfunction

  // Implemented-bit mask of a slot.
  function automatic logic [7:0] slot_mask(input logic [1:0] slot);
    logic [7:0] m;
    m = icc_pkg::MASK_TX_FORMAT;
    case (slot)
      2'h1: begin
        m = icc_pkg::MASK_IO_CFG;
      end
      2'h2: begin
        m = icc_pkg::MASK_CLK_PRI;
      end
      2'h3: begin
        m = icc_pkg::MASK_CLK_SEC;
      end
      default: begin
        m = icc_pkg::MASK_TX_FORMAT;
      end
    endcase
    return m;
  endfunction

  // Reads one register; unmapped addresses return zero.
  function automatic logic [7:0] reg_read(input logic [5:0] addr, input logic [7:0] r0,
                                          input logic [7:0] r1, input logic [7:0] r2,
                                          input logic [7:0] r3);
    logic [2:0] s;
    logic [7:0] v;
    s = reg_slot(addr);
    v = 8'h00;
    if (s[2]) begin
      case (s[1:0])
        2'h0: begin
          v = r0;
        end
        2'h1: begin
          v = r1;
        end
        2'h2: begin
          v = r2;
        end
        default: begin
          v = r3;
        end
      endcase
    end
    return v;
  endfunction

  // Pins come from outside the clock domain and pass two flip-flops first.
  icc_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in({!sen_b, sclk, sdio_in, tx_rx_select}),
    .sync_out(pins_sync)
  );

  // Enable is active low on the pin; sen_s is high inside a frame.
  // Inverted ahead of the chain so the cleared chain reads as deselected,
  // which keeps reset from looking like the start of a frame.
  assign sen_s = pins_sync[3];
  assign sclk_s = pins_sync[2];
  assign sdi_s = pins_sync[1];
  assign dir_pin_s = pins_sync[0];
  assign sclk_rise = sclk_s && !sclk_prev_q;
  assign sclk_fall = !sclk_s && sclk_prev_q;
  assign byte_in = {shift_in_q[6:0], sdi_s};
  assign edge_next = edge_cnt_q + 5'h01;

  // Serial sequencer next state. Because the serial clock is sampled, its
  // rate must stay well below a quarter of the system clock.
  always_comb begin
    sclk_prev_d = sclk_s;
    sp_d = sp_q;
    edge_cnt_d = edge_cnt_q;
    shift_in_d = shift_in_q;
    two_byte_d = two_byte_q;
    addr_d = addr_q;
    hold_d = hold_q;
    shift_out_d = shift_out_q;
    sdo_d = sdo_q;
    sdo_oe_d = sdo_oe_q;
    wr0_en = 1'h0;
    wr0_addr = addr_q;
    wr0_data = byte_in;
    wr1_en = 1'h0;
    wr1_addr = addr_q - 6'h01;
    wr1_data = byte_in;
    if (!sen_s) begin
      // Frame ended or never started: anything not committed is dropped.
      sp_d = icc_pkg::SP_IDLE;
      edge_cnt_d = 5'h00;
      sdo_oe_d = 1'h0;
    end else begin
      case (sp_q)
        icc_pkg::SP_IDLE: begin
          // Enable just fell; start collecting the instruction byte.
          sp_d = icc_pkg::SP_INSTR;
          edge_cnt_d = 5'h00;
        end
        icc_pkg::SP_INSTR: begin
          if (sclk_rise) begin
            shift_in_d = byte_in;
            edge_cnt_d = edge_next;
            if (edge_next == icc_pkg::EDGES_INSTR) begin
              two_byte_d = byte_in[icc_pkg::INSTR_TWO_BYTE];
              addr_d = byte_in[5:0];
              if (byte_in[icc_pkg::INSTR_READ]) begin
                // Second byte comes from the decremented address.
                shift_out_d = {reg_read(byte_in[5:0], regs_q[0], regs_q[1], regs_q[2],
                                        regs_q[3]),
                               reg_read(byte_in[5:0] - 6'h01, regs_q[0], regs_q[1],
                                        regs_q[2], regs_q[3])};
                sp_d = icc_pkg::SP_READ;
              end else begin
                sp_d = icc_pkg::SP_WRITE;
              end
            end
          end
        end
        icc_pkg::SP_WRITE: begin
          if (sclk_rise) begin
            shift_in_d = byte_in;
            edge_cnt_d = edge_next;
            if (edge_next == icc_pkg::EDGES_BYTE1) begin
              if (two_byte_q) begin
                // Hold the first byte; it only lands if the frame completes.
                hold_d = byte_in;
              end else begin
                wr0_en = 1'h1;
                sp_d = icc_pkg::SP_DONE;
              end
            end else if (edge_next == icc_pkg::EDGES_BYTE2) begin
              wr0_en = 1'h1;
              wr0_data = hold_q;
              wr1_en = 1'h1;
              sp_d = icc_pkg::SP_DONE;
            end
          end
        end
        icc_pkg::SP_READ: begin
          // Data leaves on falling edges, so it is stable at the next rise.
          if (sclk_fall) begin
            sdo_d = shift_out_q[15];
            shift_out_d = {shift_out_q[14:0], 1'h0};
            sdo_oe_d = 1'h1;
          end
        end
        icc_pkg::SP_DONE: begin
          // Extra edges after a completed write are ignored.
          sp_d = icc_pkg::SP_DONE;
        end
        default: begin
          sp_d = icc_pkg::SP_IDLE;
        end
      endcase
    end
  end

  // Serial sequencer registers.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sclk_prev_q <= 1'h0;
      sp_q <= icc_pkg::SP_IDLE;
      edge_cnt_q <= 5'h00;
      shift_in_q <= 8'h00;
      two_byte_q <= 1'h0;
      addr_q <= 6'h00;
      hold_q <= 8'h00;
      shift_out_q <= 16'h0000;
      sdo_q <= 1'h0;
      sdo_oe_q <= 1'h0;
    end else begin
      sclk_prev_q <= sclk_prev_d;
      sp_q <= sp_d;
      edge_cnt_q <= edge_cnt_d;
      shift_in_q <= shift_in_d;
      two_byte_q <= two_byte_d;
      addr_q <= addr_d;
      hold_q <= hold_d;
      shift_out_q <= shift_out_d;
      sdo_q <= sdo_d;
      sdo_oe_q <= sdo_oe_d;
    end
  end

  // Register file next values; implemented bits are kept as written, the rest cleared,
  // while unused multiplier codes are stored as written.
  always_comb begin
    logic [2:0] s0;
    logic [2:0] s1;
    s0 = reg_slot(wr0_addr);
    s1 = reg_slot(wr1_addr);
    for (int i = 0; i < 4; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (wr0_en && s0[2]) begin
      regs_d[s0[1:0]] = wr0_data & slot_mask(s0[1:0]);
    end
    if (wr1_en && s1[2]) begin
      regs_d[s1[1:0]] = wr1_data & slot_mask(s1[1:0]);
    end
  end

  // Register file storage with documented reset values.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      regs_q[0] <= icc_pkg::RST_TX_FORMAT;
      regs_q[1] <= icc_pkg::RST_IO_CFG;
      regs_q[2] <= icc_pkg::RST_CLK_PRI;
      regs_q[3] <= icc_pkg::RST_CLK_SEC;
    end else begin
      for (int i = 0; i < 4; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // Decodes control fields into the steering outputs.
  always_comb begin
    logic [1:0] interp;
    logic [7:0] io;
    logic [7:0] ck1;
    logic [7:0] ck2;
    logic fd;
    interp = regs_q[0][icc_pkg::INTERP_LSB +: icc_pkg::INTERP_W];
    io = regs_q[1];
    ck1 = regs_q[2];
    ck2 = regs_q[3];
    // Clone mode overrules the duplex select bit.
    fd = io[icc_pkg::IO_DUPLEX] && !io[icc_pkg::IO_CLONE];
    // Code 11 is undefined and is treated as bypass.
    outs_d[0] = (interp != icc_pkg::INTERP_2X) && (interp != icc_pkg::INTERP_4X);
    outs_d[1] = (interp == icc_pkg::INTERP_2X);
    outs_d[2] = (interp == icc_pkg::INTERP_4X);
    // Loop-back relies on the host having chosen full duplex.
    outs_d[3] = io[icc_pkg::IO_LOOPBACK];
    outs_d[4] = fd;
    outs_d[5] = !fd && io[icc_pkg::IO_WIDTH];
    outs_d[6] = !fd && !io[icc_pkg::IO_WIDTH];
    outs_d[7] = io[icc_pkg::IO_CLONE];
    // Register direction wins over the pin only when overridden.
    outs_d[8] = io[icc_pkg::IO_DIR_OVERRIDE] ? io[icc_pkg::IO_DIRECTION]
                                              : dir_pin_s;
    outs_d[9] = ck1[icc_pkg::CLK_BYPASS];
    outs_d[10] = ck1[icc_pkg::CLK_DIV5];
    outs_d[11] = ck1[icc_pkg::CLK_RX_HALF];
    outs_d[12] = ck1[icc_pkg::CLK_ALT_TIMING];
    outs_d[13] = ck2[icc_pkg::CLK_AUX_OUT] && (aux_clock_config_enable || fd);
    outs_d[14] = ck2[icc_pkg::CLK_LOOP_BW];
    // Unused codes leave the last valid factor in place.
    if (ck1[icc_pkg::MULT_LSB +: icc_pkg::MULT_W] <= icc_pkg::MULT_CODE_MAX) begin
      factor_d = ck1[icc_pkg::MULT_LSB +: icc_pkg::MULT_W];
    end else begin
      factor_d = factor_q;
    end
  end

  // Output registers; the multiplier itself is never stopped by bypass.
  // Reset shows bypass and full duplex, matching the reset register contents.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      outs_q <= 15'h0011;
      factor_q <= icc_pkg::MULT_CODE_1X;
    end else begin
      outs_q <= outs_d;
      factor_q <= factor_d;
    end
  end

  assign sdo_out = sdo_q;
  assign sdo_oe = sdo_oe_q;
  assign tx_interp_bypass = outs_q[0];
  assign tx_interp_2x = outs_q[1];
  assign tx_interp_4x = outs_q[2];
  assign digital_loopback_enable = outs_q[3];
  assign full_duplex_mode = outs_q[4];
  assign half_duplex_narrow_mode = outs_q[5];
  assign half_duplex_wide_mode = outs_q[6];
  assign clone_mode_enable = outs_q[7];
  assign half_duplex_direction = outs_q[8];
  assign mult_bypass = outs_q[9];
  assign multiplier_output_fifth_divide = outs_q[10];
  assign rx_clock_half = outs_q[11];
  assign rx_clock_from_multiplier = outs_q[12];
  assign multiplied_clock_to_aux_output = outs_q[13];
  assign mult_loop_alt_bandwidth = outs_q[14];
  assign mult_factor_sel = factor_q;

endmodule

// ==== icc_config_properties.sv ====
// Concurrent checks on the ports of the configuration register bank.
`timescale 1ns/100ps
module icc_config_checker (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Serial port and pins.
  input wire logic sen_b,
  input wire logic sclk,
  input wire logic sdio_in,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic tx_rx_select,
  input wire logic aux_clock_config_enable,
  // Decoded controls.
  input wire logic tx_interp_bypass,
  input wire logic tx_interp_2x,
  input wire logic tx_interp_4x,
  input wire logic digital_loopback_enable,
  input wire logic full_duplex_mode,
  input wire logic half_duplex_narrow_mode,
  input wire logic half_duplex_wide_mode,
  input wire logic clone_mode_enable,
  input wire logic half_duplex_direction,
  input wire logic mult_bypass,
  input wire logic [2:0] mult_factor_sel,
  input wire logic multiplier_output_fifth_divide,
  input wire logic rx_clock_half,
  input wire logic rx_clock_from_multiplier,
  input wire logic multiplied_clock_to_aux_output,
  input wire logic mult_loop_alt_bandwidth
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // Cycles since the serial enable went high, saturating so it never wraps.
  logic [3:0] idle_q;
  logic [3:0] idle_d;

  // Next idle count; a low enable restarts it.
  always_comb begin
    idle_d = idle_q;
    if (!sen_b) begin
      idle_d = 4'h0;
    end else if (idle_q != 4'hF) begin
      idle_d = idle_q + 4'h1;
    end
  end

  // Register the count; reset clears it so the first cycles are not judged.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      idle_q <= 4'h0;
    end else begin
      idle_q <= idle_d;
    end
  end

  a_interp_one_hot: assert property (
    $onehot({tx_interp_bypass, tx_interp_2x, tx_interp_4x}))
    else $error("interpolation selects not one-hot");
  a_iface_mode_one: assert property (
    $onehot({full_duplex_mode, half_duplex_narrow_mode, half_duplex_wide_mode}))
    else $error("interface mode outputs not one-hot");
  a_clone_no_duplex: assert property (
    clone_mode_enable |-> !full_duplex_mode)
    else $error("full duplex reported in clone mode");
  a_mult_code_legal: assert property (
    mult_factor_sel <= 3'h4)
    else $error("multiplier factor outside the defined codes");
  a_aux_out_allowed: assert property (
    multiplied_clock_to_aux_output |->
      ($past(aux_clock_config_enable) || full_duplex_mode || $past(full_duplex_mode)))
    else $error("aux clock output enabled without permission");
  a_config_idle_still: assert property (
    idle_q >= 4'h4 |-> $stable({tx_interp_bypass, tx_interp_2x, tx_interp_4x,
      digital_loopback_enable, full_duplex_mode, half_duplex_narrow_mode,
      half_duplex_wide_mode, clone_mode_enable, mult_bypass, mult_factor_sel,
      multiplier_output_fifth_divide, rx_clock_half, rx_clock_from_multiplier,
      mult_loop_alt_bandwidth}))
    else $error("configuration changed outside a serial frame");
  a_sdo_idle_off: assert property (
    idle_q >= 4'h6 |-> !sdo_oe)
    else $error("serial output driven while deselected");
  a_reset_decode_ok: assert property (
    $rose(rst_b) |-> tx_interp_bypass && mult_factor_sel == 3'h0
      ##1 full_duplex_mode && !digital_loopback_enable && !mult_bypass)
    else $error("outputs after reset do not match the reset registers");
endmodule

bind icc_config_top icc_config_checker u_chk (.clock, .rst_b, .sen_b, .sclk, .sdio_in,
  .sdo_out, .sdo_oe, .tx_rx_select, .aux_clock_config_enable, .tx_interp_bypass,
  .tx_interp_2x, .tx_interp_4x, .digital_loopback_enable, .full_duplex_mode,
  .half_duplex_narrow_mode, .half_duplex_wide_mode, .clone_mode_enable,
  .half_duplex_direction, .mult_bypass, .mult_factor_sel, .multiplier_output_fifth_divide,
  .rx_clock_half, .rx_clock_from_multiplier, .multiplied_clock_to_aux_output,
  .mult_loop_alt_bandwidth);

// ==== icc_host_model.sv ====
// Host controller model that drives the serial configuration port.
`timescale 1ns/100ps
module icc_host_model (
  // Clock.
  clock,
  // Serial pins seen from the host.
  sen_b,
  sclk,
  sdio_in,
  sdo_out
);
  input wire logic clock;
  output logic sen_b;
  output logic sclk;
  output logic sdio_in;
  input wire logic sdo_out;

  // Clocks per serial clock phase; six keeps clear of the four-clock minimum.
  localparam int HALF = 6;

  // Idle pins: deselected, serial clock parked low.
  initial begin
    sen_b = 1'b1;
    sclk = 1'b0;
    sdio_in = 1'b0;
  end

  // Shifts nbits of word MSB first; fewer bits than the frame needs aborts it.
  task automatic frame(input logic [23:0] word, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge clock) sen_b <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 0; i < nbits; i++) begin
      @(posedge clock) sdio_in <= word[23 - i];
      repeat (HALF) @(posedge clock);
      // Read data is taken at the rise, a full phase after the falling edge.
      rd = {rd[14:0], sdo_out};
      sclk <= 1'b1;
      repeat (HALF) @(posedge clock);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clock);
    sen_b <= 1'b1;
    // The released data line must not look like a held value.
    sdio_in <= ~sdio_in;
    repeat (6) @(posedge clock);
  endtask
endmodule

// ==== icc_config_top_test.sv ====
// Self-checking testbench for the configuration register bank.
`timescale 1ns/100ps
module icc_config_top_test;
  // Stimulus and observed pins.
  logic clock, rst_b, tx_rx_select, aux_clock_config_enable;
  logic sen_b, sclk, sdio_in, sdo_out, sdo_oe;
  logic tx_interp_bypass, tx_interp_2x, tx_interp_4x, digital_loopback_enable;
  logic full_duplex_mode, half_duplex_narrow_mode, half_duplex_wide_mode;
  logic clone_mode_enable, half_duplex_direction, mult_bypass;
  logic [2:0] mult_factor_sel;
  logic multiplier_output_fifth_divide, rx_clock_half, rx_clock_from_multiplier;
  logic multiplied_clock_to_aux_output, mult_loop_alt_bandwidth;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [15:0] rd;
  // Interface register writes and packed expectation {lb,clone,dir,fd,narrow,wide}.
  logic [7:0] io_wr [6] = '{8'h30, 8'h04, 8'h00, 8'h02, 8'h0E, 8'h15};
  logic [7:0] io_ex [6] = '{8'h2C, 8'h0A, 8'h09, 8'h01, 8'h0A, 8'h1A};
  // Clock register writes and outputs; codes 5 and 7 keep the last factor.
  logic [7:0] ck_wr [9] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07};
  logic [7:0] ck_ex [9] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h02, 8'h03, 8'h04, 8'h04, 8'h04};

  always #5 clock = ~clock;

  icc_config_top u_dut (.clock, .rst_b, .sen_b, .sclk, .sdio_in, .sdo_out, .sdo_oe,
    .tx_rx_select, .aux_clock_config_enable, .tx_interp_bypass, .tx_interp_2x,
    .tx_interp_4x, .digital_loopback_enable, .full_duplex_mode, .half_duplex_narrow_mode,
    .half_duplex_wide_mode, .clone_mode_enable, .half_duplex_direction, .mult_bypass,
    .mult_factor_sel, .multiplier_output_fifth_divide, .rx_clock_half,
    .rx_clock_from_multiplier, .multiplied_clock_to_aux_output, .mult_loop_alt_bandwidth);

  icc_host_model u_host (.clock, .sen_b, .sclk, .sdio_in, .sdo_out);

  // Compares one value against its expectation and counts both outcomes.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // One-byte register write.
  task automatic wr(input logic [5:0] addr, input logic [7:0] data);
    u_host.frame({2'b00, addr, data, 8'h00}, 16, rd);
  endtask

  // One-byte register read compared with an expected value.
  task automatic rdreg(input logic [5:0] addr, input logic [7:0] exp);
    u_host.frame({2'b10, addr, 16'h0000}, 16, rd);
    check(rd[7:0], exp);
  endtask

  // Packed views of the decoded outputs.
  function automatic logic [7:0] interp_v();
    return {5'h00, tx_interp_4x, tx_interp_2x, tx_interp_bypass};
  endfunction
  function automatic logic [7:0] io_v();
    return {2'b00, digital_loopback_enable, clone_mode_enable, half_duplex_direction,
      full_duplex_mode, half_duplex_narrow_mode, half_duplex_wide_mode};
  endfunction
  function automatic logic [7:0] ck_v();
    return {mult_bypass, 1'b0, rx_clock_half, rx_clock_from_multiplier,
      multiplier_output_fifth_divide, mult_factor_sel};
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog so a stuck sequence still reaches the verdict.
  initial begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    tx_rx_select = 1'b1;
    aux_clock_config_enable = 1'b0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    // Reset contents and the decode of them.
    rdreg(6'h13, 8'h00);
    rdreg(6'h14, 8'h10);
    rdreg(6'h15, 8'h00);
    rdreg(6'h16, 8'h00);
    check(interp_v(), 8'h01);
    check(io_v(), 8'h0C);
    // Every interpolation code; 11 falls back to bypass.
    for (int c = 0; c < 4; c++) begin
      wr(6'h13, 8'(c));
      check(interp_v(), (c == 1) ? 8'h02 : (c == 2) ? 8'h04 : 8'h01);
    end
    // Interface modes, direction, loop-back with full duplex, clone mode.
    for (int i = 0; i < 6; i++) begin
      wr(6'h14, io_wr[i]);
      check(io_v(), io_ex[i]);
      rdreg(6'h14, io_wr[i]);
    end
    // Without override the direction follows the pin.
    wr(6'h14, 8'h04);
    tx_rx_select <= 1'b0;
    repeat (5) @(posedge clock);
    check(io_v(), 8'h02);
    // Clock distribution bits and multiplier codes 0, 2, 3, 4, 5 and 7.
    for (int i = 0; i < 9; i++) begin
      wr(6'h15, ck_wr[i]);
      check(ck_v(), ck_ex[i]);
      rdreg(6'h15, ck_wr[i]);
    end
    // Aux clock output gated by permission; loop bandwidth select.
    wr(6'h16, 8'hFF);
    rdreg(6'h16, 8'h24);
    check({6'h00, multiplied_clock_to_aux_output, mult_loop_alt_bandwidth}, 8'h01);
    aux_clock_config_enable <= 1'b1;
    repeat (3) @(posedge clock);
    check({7'h00, multiplied_clock_to_aux_output}, 8'h01);
    aux_clock_config_enable <= 1'b0;
    wr(6'h14, 8'h10);
    check({7'h00, multiplied_clock_to_aux_output}, 8'h01);
    // Two-byte write lands in the address and the one below it.
    u_host.frame(24'h560083, 24, rd);
    check(ck_v(), 8'h83);
    check({7'h00, mult_loop_alt_bandwidth}, 8'h00);
    // Two-byte read returns the address and then the one below it.
    u_host.frame(24'hD50000, 24, rd);
    check(rd[15:8], 8'h83);
    check(rd[7:0], 8'h10);
    check({7'h00, sdo_oe}, 8'h00);
    // Frames cut short write nothing.
    u_host.frame(24'h562400, 16, rd);
    u_host.frame(24'h130200, 12, rd);
    rdreg(6'h16, 8'h00);
    check(interp_v(), 8'h01);
    // Unmapped address is dropped and reads zero.
    wr(6'h20, 8'h5A);
    rdreg(6'h20, 8'h00);
    // Second reset in mid-run restores defaults.
    rst_b <= 1'b0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    rdreg(6'h15, 8'h00);
    check(io_v(), 8'h04);
    wrap_up();
  end
endmodule
